// [common/servo_ctrl_pkg.sv]
package servo_ctrl_pkg;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  // Printed offsets are word indices; the byte address is four times.
  localparam logic [9:0] IDX_LINE_LEFT_LEVEL = 10'h03B;
  localparam logic [9:0] IDX_LINE_RIGHT_LEVEL = 10'h03C;
  localparam logic [9:0] IDX_SOURCE_SELECT = 10'h03D;
  localparam logic [9:0] IDX_SERVO_ENABLE = 10'h043;
  localparam logic [9:0] IDX_SERVO_TRIGGER = 10'h044;
  localparam logic [9:0] IDX_BURST_LINE = 10'h047;
  localparam logic [9:0] IDX_BURST_PHONES = 10'h048;
  localparam int ADDR_W = 12;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int LVL_SILENCE_BIT = 8;
  localparam int LVL_COMMIT_BIT = 7;
  localparam int LVL_ZC_BIT = 6;
  localparam int LVL_GAIN_LSB = 0;
  localparam int GAIN_W = 6;
  localparam int SEL_PHONES_LEFT_BIT = 3;
  localparam int SEL_PHONES_RIGHT_BIT = 2;
  localparam int SEL_LINE_LEFT_BIT = 1;
  localparam int SEL_LINE_RIGHT_BIT = 0;
  localparam int TRIG_ONCE_LSB = 12;
  localparam int TRIG_BURST_LSB = 8;
  localparam int TRIG_POWERUP_LSB = 4;
  localparam int TRIG_CONVWRITE_LSB = 0;
  localparam int BURST_W = 7;
  localparam int NUM_CHAN = 4;
  localparam int NUM_MODE = 4;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [5:0] GAIN_RESET = 6'h39;
  localparam logic [6:0] BURST_RESET = 7'h2A;

  // Correction modes, one bit each, in busy-vector order.
  typedef enum logic [3:0] {
    MODE_CONVWRITE = 4'h1,
    MODE_POWERUP = 4'h2,
    MODE_BURST = 4'h4,
    MODE_ONCE = 4'h8
  } servo_mode_type;

  // Sequencer states of one servo channel.
  typedef enum logic [1:0] {
    SERVO_IDLE = 2'h1,
    SERVO_RUN = 2'h2
  } servo_state_type;

endpackage : servo_ctrl_pkg

// [design/servo_channel_engine.sv]
module servo_channel_engine
  import servo_ctrl_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic [servo_ctrl_pkg::NUM_MODE-1:0] startReq, // Write-1 pulses.
  input wire logic chanEnable, // Servo enable of this channel.
  input wire logic [servo_ctrl_pkg::BURST_W-1:0] burstCount, // N gives N+1.
  input wire logic stepDone, // One correction update finished.
  output logic [servo_ctrl_pkg::NUM_MODE-1:0] busy, // Running mode.
  output logic stepReq // Asks the analogue servo for updates.
);

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    servo_state_type state;
    logic [NUM_MODE-1:0] mode;
    logic [BURST_W-1:0] remaining;
  } engine_type;

  engine_type q, d;
  logic finishing;

  // Next state; a start that lands on the finishing update is accepted.
  always_comb begin
    d = q;
    finishing = 1'b0;
    unique case (q.state)
      SERVO_IDLE: begin
      end
      SERVO_RUN: begin
        if (!chanEnable) begin
          d.state = SERVO_IDLE;
          d.mode = '0;
        end else if (stepDone) begin
          if (q.remaining == '0) begin
            finishing = 1'b1;
            d.state = SERVO_IDLE;
            d.mode = '0;
          end else begin
            d.remaining = q.remaining - 1'b1;
          end
        end
      end
    endcase
    // Only one mode runs at a time; higher bits win a tie.
    if (chanEnable && |startReq
        && (q.state == SERVO_IDLE || finishing)) begin
      d.state = SERVO_RUN;
      d.remaining = '0;
      if (startReq[3]) begin
        d.mode = MODE_ONCE;
      end else if (startReq[2]) begin
        d.mode = MODE_BURST;
        d.remaining = burstCount;
      end else if (startReq[1]) begin
        d.mode = MODE_POWERUP;
      end else begin
        d.mode = MODE_CONVWRITE;
      end
    end
  end

  // Register the state.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '{state: SERVO_IDLE, mode: '0, remaining: '0};
    end else begin
      q <= d;
    end
  end

  assign busy = q.mode;
  assign stepReq = (q.state == SERVO_RUN);

endmodule : servo_channel_engine

// [design/output_path_and_offset_servo_ctrl.sv]
// Chosen here: register access over APB.
module output_path_and_offset_servo_ctrl (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic reset_n, // Synchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, 1 is write.
  input wire logic [servo_ctrl_pkg::ADDR_W-1:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error, unmapped address.
  input wire logic [1:0] zeroCross, // Line zero crossing, [1] right.
  input wire logic [3:0] servoStepDone, // Servo update done per channel.
  output logic [1:0] lineSilence, // Line mute, [1] right, [0] left.
  output logic [1:0] lineZeroCrossEn, // Line zero-cross gating enables.
  output logic [11:0] lineGain, // Applied gains, [11:6] right.
  output logic [3:0] bypassSel, // Output source selects, 1 is bypass.
  output logic [3:0] servoEnable, // Servo enables per channel.
  output logic [3:0] servoStepReq // Servo update request per channel.
);
  import servo_ctrl_pkg::*;

  // ************************************************************
  // Address map
  // ************************************************************
  localparam logic [ADDR_W-1:0] A_LEFT = {IDX_LINE_LEFT_LEVEL, 2'b00};
  localparam logic [ADDR_W-1:0] A_RIGHT = {IDX_LINE_RIGHT_LEVEL, 2'b00};
  localparam logic [ADDR_W-1:0] A_SEL = {IDX_SOURCE_SELECT, 2'b00};
  localparam logic [ADDR_W-1:0] A_SEN = {IDX_SERVO_ENABLE, 2'b00};
  localparam logic [ADDR_W-1:0] A_TRIG = {IDX_SERVO_TRIGGER, 2'b00};
  localparam logic [ADDR_W-1:0] A_BLINE = {IDX_BURST_LINE, 2'b00};
  localparam logic [ADDR_W-1:0] A_BPHN = {IDX_BURST_PHONES, 2'b00};

  // ************************************************************
  // State
  // ************************************************************
  // Index 1 is the right line channel, index 0 the left.
  typedef struct packed {
    logic [1:0][GAIN_W-1:0] gainPend;
    logic [1:0][GAIN_W-1:0] gainApplied;
    logic [1:0] silence;
    logic [1:0] zcEn;
    logic [1:0] applyWait;
    logic [3:0] srcSel;
    logic [3:0] servoEn;
    logic [BURST_W-1:0] burstLine;
    logic [BURST_W-1:0] burstPhones;
    logic [31:0] rdata;
    logic slvErr;
    logic [1:0] zcMeta;
    logic [1:0] zcSync;
    logic [1:0] zcPrev;
    logic [3:0] doneMeta;
    logic [3:0] doneSync;
    logic [3:0] donePrev;
  } ctrl_type;

  ctrl_type q, d;
  logic setup, wrEn;
  logic [15:0] mask;
  logic [15:0] wmasked;
  logic hit;
  logic [31:0] rmux;
  logic commit;
  logic [1:0] zcEdge;
  logic [3:0] doneEdge;
  logic [NUM_CHAN-1:0][NUM_MODE-1:0] startReq;
  logic [NUM_CHAN-1:0][NUM_MODE-1:0] busy;
  logic [15:0] trigRead;

  // ************************************************************
  // Bus decode
  // ************************************************************
  // Zero wait states: read data is captured in the setup cycle.
  assign setup = psel && !penable;
  assign wrEn = setup && pwrite;
  assign mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wmasked = pwdata[15:0] & mask;
  assign commit = wrEn && wmasked[LVL_COMMIT_BIT]
    && (paddr == A_LEFT || paddr == A_RIGHT);

  // Merge a write into a stored field, honouring the byte strobes.
  function automatic logic [15:0] merge(input logic [15:0] old);
    merge = (pwdata[15:0] & mask) | (old & ~mask);
  endfunction : merge

  // Trigger bits read as the running modes of each channel.
  always_comb begin
    trigRead = '0;
    for (int c = 0; c < NUM_CHAN; c++) begin
      trigRead[TRIG_ONCE_LSB + c] = busy[c][3];
      trigRead[TRIG_BURST_LSB + c] = busy[c][2];
      trigRead[TRIG_POWERUP_LSB + c] = busy[c][1];
      trigRead[TRIG_CONVWRITE_LSB + c] = busy[c][0];
    end
  end

  // Read multiplexer; the commit bit always reads back as zero.
  always_comb begin
    hit = 1'b1;
    rmux = '0;
    unique case (paddr)
      A_LEFT: rmux[8:0] = {q.silence[0], 1'b0, q.zcEn[0], q.gainPend[0]};
      A_RIGHT: rmux[8:0] = {q.silence[1], 1'b0, q.zcEn[1], q.gainPend[1]};
      A_SEL: rmux[3:0] = q.srcSel;
      A_SEN: rmux[3:0] = q.servoEn;
      A_TRIG: rmux[15:0] = trigRead;
      A_BLINE: rmux[BURST_W-1:0] = q.burstLine;
      A_BPHN: rmux[BURST_W-1:0] = q.burstPhones;
      default: hit = 1'b0;
    endcase
  end

  // ************************************************************
  // Trigger decode
  // ************************************************************
  // A written 1 becomes a one-cycle start pulse to the channel.
  always_comb begin
    for (int c = 0; c < NUM_CHAN; c++) begin
      if (wrEn && paddr == A_TRIG) begin
        startReq[c] = {wmasked[TRIG_ONCE_LSB + c],
          wmasked[TRIG_BURST_LSB + c], wmasked[TRIG_POWERUP_LSB + c],
          wmasked[TRIG_CONVWRITE_LSB + c]};
      end else begin
        startReq[c] = '0;
      end
    end
  end

  // Edge pulses come only from the second synchroniser stage onward.
  assign zcEdge = q.zcSync & ~q.zcPrev;
  assign doneEdge = q.doneSync & ~q.donePrev;

  // ************************************************************
  // Register update
  // ************************************************************
  always_comb begin
    logic [15:0] m;
    m = '0;
    d = q;
    d.zcMeta = zeroCross;
    d.zcSync = q.zcMeta;
    d.zcPrev = q.zcSync;
    d.doneMeta = servoStepDone;
    d.doneSync = q.doneMeta;
    d.donePrev = q.doneSync;
    if (setup) begin
      d.rdata = pwrite ? 32'h0000_0000 : rmux;
      d.slvErr = !hit;
    end
    // Each line channel waits for its zero crossing when gating is on.
    for (int c = 0; c < 2; c++) begin
      if (q.applyWait[c] && (!q.zcEn[c] || zcEdge[c])) begin
        d.gainApplied[c] = q.gainPend[c];
        d.applyWait[c] = 1'b0;
      end
    end
    if (wrEn) begin
      unique case (paddr)
        A_LEFT: begin
          m = merge({7'h00, q.silence[0], 1'b0, q.zcEn[0], q.gainPend[0]});
          d.silence[0] = m[LVL_SILENCE_BIT];
          d.zcEn[0] = m[LVL_ZC_BIT];
          d.gainPend[0] = m[LVL_GAIN_LSB +: GAIN_W];
        end
        A_RIGHT: begin
          m = merge({7'h00, q.silence[1], 1'b0, q.zcEn[1], q.gainPend[1]});
          d.silence[1] = m[LVL_SILENCE_BIT];
          d.zcEn[1] = m[LVL_ZC_BIT];
          d.gainPend[1] = m[LVL_GAIN_LSB +: GAIN_W];
        end
        A_SEL: begin
          m = merge({12'h000, q.srcSel});
          d.srcSel = m[3:0];
        end
        A_SEN: begin
          m = merge({12'h000, q.servoEn});
          d.servoEn = m[3:0];
        end
        A_BLINE: begin
          m = merge({9'h000, q.burstLine});
          d.burstLine = m[BURST_W-1:0];
        end
        A_BPHN: begin
          m = merge({9'h000, q.burstPhones});
          d.burstPhones = m[BURST_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // A commit restarts the wait, so the newest pending gain is taken.
    if (commit) begin
      d.applyWait = 2'b11;
    end
  end

  // Register the whole state.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q <= '{gainPend: {GAIN_RESET, GAIN_RESET},
        gainApplied: {GAIN_RESET, GAIN_RESET},
        burstLine: BURST_RESET, burstPhones: BURST_RESET,
        default: '0};
    end else begin
      q <= d;
    end
  end

  // ************************************************************
  // Servo channels
  // ************************************************************
  // Channels 0 and 1 are the phones, 2 and 3 the line outputs.
  for (genvar c = 0; c < NUM_CHAN; c++) begin : gen_servo
    servo_channel_engine servo_channel_engine_inst (
      .clk(clk),
      .reset_n(reset_n),
      .startReq(startReq[c]),
      .chanEnable(q.servoEn[c]),
      .burstCount(c < 2 ? q.burstPhones : q.burstLine),
      .stepDone(doneEdge[c]),
      .busy(busy[c]),
      .stepReq(servoStepReq[c])
    );
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata = q.rdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && q.slvErr;
  assign lineSilence = q.silence;
  assign lineZeroCrossEn = q.zcEn;
  assign lineGain = {q.gainApplied[1], q.gainApplied[0]};
  assign bypassSel = q.srcSel;
  assign servoEnable = q.servoEn;

endmodule : output_path_and_offset_servo_ctrl

// [verification/output_path_and_offset_servo_ctrl_assertions.sv]
module servo_ctrl_checker (
  input wire logic clk, // Register clock.
  input wire logic reset_n, // Reset, active low.
  input wire logic psel, // Select.
  input wire logic penable, // Access phase.
  input wire logic pwrite, // Direction.
  input wire logic [servo_ctrl_pkg::ADDR_W-1:0] paddr, // Byte address.
  input wire logic [31:0] pwdata, // Write data.
  input wire logic [3:0] pstrb, // Byte strobes.
  input wire logic [1:0] lineSilence, // Line mutes.
  input wire logic [1:0] lineZeroCrossEn, // Zero-cross enables.
  input wire logic [11:0] lineGain, // Applied gains.
  input wire logic [3:0] bypassSel, // Source selects.
  input wire logic [3:0] servoEnable, // Servo enables.
  input wire logic [3:0] servoStepDone, // Update finished.
  input wire logic [3:0] servoStepReq // Update request.
);
  timeunit 1ns;
  timeprecision 1ps;
  import servo_ctrl_pkg::*;
  logic wr;
  // A write lands at its setup edge, so outputs follow one edge later.
  assign wr = psel && !penable && pwrite;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_mute;
    wr && paddr == 12'h0F0 && pstrb[1]
      |=> lineSilence[1] == $past(pwdata[8]);
  endproperty
  a_mute: assert property (p_mute) else $error("mute wrong");
  property p_zc;
    wr && paddr == 12'h0F0 && pstrb[0]
      |=> lineZeroCrossEn[1] == $past(pwdata[6]);
  endproperty
  a_zc: assert property (p_zc) else $error("zero-cross wrong");
  property p_bypass;
    wr && paddr == 12'h0F4 && pstrb[0] |=> bypassSel == $past(pwdata[3:0]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("source wrong");
  property p_enable;
    wr && paddr == 12'h10C && pstrb[0]
      |=> servoEnable == $past(pwdata[3:0]);
  endproperty
  a_enable: assert property (p_enable) else $error("enable wrong");
  // Without zero-cross gating the gain lands two edges after the write.
  property p_gain;
    wr && paddr == 12'h0F0 && pstrb == 4'h3 && pwdata[7] && !pwdata[6]
      |-> ##2 lineGain[11:6] == $past(pwdata[5:0], 2);
  endproperty
  a_gain: assert property (p_gain) else $error("commit wrong");
  property p_start;
    wr && paddr == 12'h110 && pstrb[1] && pwdata[12] && servoEnable[0]
      && !servoStepReq[0] |-> ##[1:2] servoStepReq[0];
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_ignore;
    wr && paddr == 12'h110 && pstrb[1] && pwdata[12] && !servoEnable[0]
      && !servoStepReq[0] |=> !servoStepReq[0] [*2];
  endproperty
  a_ignore: assert property (p_ignore) else $error("bad start");
  // A running correction may only end on an update or an abort.
  property p_hold;
    (servoStepReq[0] && servoEnable[0] && !servoStepDone[0]) [*6]
      ##1 servoEnable[0] |-> servoStepReq[0];
  endproperty
  a_hold: assert property (p_hold) else $error("early end");
endmodule : servo_ctrl_checker

// [verification/output_path_and_offset_servo_ctrl_tb_top.sv]
module output_path_and_offset_servo_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import servo_ctrl_pkg::*;
  localparam logic [11:0] ADR [7] = '{12'h0EC, 12'h0F0, 12'h0F4, 12'h10C,
    12'h110, 12'h11C, 12'h120};
  localparam logic [31:0] RST [7] = '{32'h39, 32'h39, 32'h0, 32'h0, 32'h0,
    32'h2A, 32'h2A};
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, bypassSel, servoEnable, servoStepDone, servoStepReq;
  logic [1:0] zeroCross, lineSilence, lineZeroCrossEn;
  logic [11:0] lineGain;
  logic [32:0] expQ[$];
  int badCount, nChecks, seed;

  output_path_and_offset_servo_ctrl output_path_and_offset_servo_ctrl_inst (
    .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .zeroCross(zeroCross), .servoStepDone(servoStepDone),
    .lineSilence(lineSilence), .lineZeroCrossEn(lineZeroCrossEn),
    .lineGain(lineGain), .bypassSel(bypassSel), .servoEnable(servoEnable),
    .servoStepReq(servoStepReq));

  // ************
  // Bus and checking tasks
  // ************
  task automatic check(input string what, input logic [32:0] exp,
    input logic [32:0] got);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : reportAndStop

  // Starts on a fresh edge so a release is never driven twice in a step.
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask : rd

  // The done line is held two cycles so the synchroniser cannot miss it.
  task automatic pulse(input int c);
    @(posedge clk);
    servoStepDone[c] <= 1'b1;
    repeat (2) @(posedge clk);
    servoStepDone[c] <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : pulse

  // The clock toggles every half period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Each completed read is compared with the oldest noted expectation.
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      if (expQ.size() == 0) begin
        check("unplanned read", 33'h0, 33'h1);
      end else begin
        check("read data", expQ.pop_front(), {pslverr, prdata});
      end
    end
  end

  // Cuts a hang short; the tests need far fewer cycles.
  initial begin
    repeat (20000) @(posedge clk);
    badCount++;
    reportAndStop();
  end

  // ************
  // Test sequence
  // ************
  initial begin
    logic [31:0] v;
    logic [11:0] a;
    logic [3:0] s;
    logic [3:0] sh [2];
    int c, n;
    seed = 88;
    sh = '{4'h0, 4'h0};
    {reset_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    zeroCross = 2'h0;
    servoStepDone = 4'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(negedge clk);
    check("reset gains", 33'hE79, 33'(lineGain));
    for (int i = 0; i < 7; i++) begin
      rd(ADR[i], {1'b0, RST[i]});
    end
    rd(12'h004, {1'b1, 32'h0});
    $display("test reset done");
    // Random selects and enables; the last writes carry no strobes.
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      a = (i % 2) ? 12'h10C : 12'h0F4;
      s = (i < 6) ? 4'hF : 4'h0;
      apb(1'b1, a, v, s);
      if (s != 4'h0) sh[i % 2] = v[3:0];
      rd(a, 33'(sh[i % 2]));
      @(negedge clk);
      check("sel", 33'(sh[0]), 33'(bypassSel));
      check("enables", 33'(sh[1]), 33'(servoEnable));
    end
    $display("test selects done");
    apb(1'b1, 12'h0EC, 32'h000, 4'h3);
    apb(1'b1, 12'h0F0, 32'h13F, 4'h3);
    @(negedge clk);
    check("silence", 33'h2, 33'(lineSilence));
    check("held gain", 33'hE79, 33'(lineGain));
    apb(1'b1, 12'h0F0, 32'h0BF, 4'h3);
    @(negedge clk);
    check("both gains", 33'hFC0, 33'(lineGain));
    apb(1'b1, 12'h0F0, 32'h0D0, 4'h3);
    repeat (4) @(negedge clk);
    check("zc enable", 33'h2, 33'(lineZeroCrossEn));
    check("gated gain", 33'hFC0, 33'(lineGain));
    @(posedge clk);
    zeroCross <= 2'h2;
    repeat (6) @(negedge clk);
    check("crossed gain", 33'h400, 33'(lineGain));
    @(posedge clk);
    zeroCross <= 2'h0;
    $display("test gains done");
    // Every trigger bit in turn, with series counts 2 and 0.
    apb(1'b1, 12'h11C, 32'h2, 4'h3);
    apb(1'b1, 12'h120, 32'h0, 4'h3);
    apb(1'b1, 12'h10C, 32'hF, 4'h3);
    for (int b = 0; b < 16; b++) begin
      c = b % 4;
      n = (b / 4 == 2 && c >= 2) ? 3 : 1;
      apb(1'b1, 12'h110, 32'h1 << b, 4'h3);
      rd(12'h110, 33'(32'h1 << b));
      for (int k = 0; k < n; k++) begin
        @(negedge clk);
        check("running", 33'(4'h1 << c), 33'(servoStepReq));
        pulse(c);
      end
      @(negedge clk);
      check("finished", 33'h0, 33'(servoStepReq));
      rd(12'h110, 33'h0);
    end
    apb(1'b1, 12'h10C, 32'h0, 4'h3);
    apb(1'b1, 12'h110, 32'hF000, 4'h3);
    rd(12'h110, 33'h0);
    @(negedge clk);
    check("ignored", 33'h0, 33'(servoStepReq));
    $display("test servo done");
    reportAndStop();
  end
endmodule : output_path_and_offset_servo_ctrl_tb_top

bind output_path_and_offset_servo_ctrl
  servo_ctrl_checker servo_ctrl_checker_inst (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .lineSilence(lineSilence), .lineZeroCrossEn(lineZeroCrossEn),
  .lineGain(lineGain), .bypassSel(bypassSel), .servoEnable(servoEnable),
  .servoStepDone(servoStepDone), .servoStepReq(servoStepReq));
